// File: dv/ptpc_clock_events_monitor.sv
// Assertion checker for the time clock and target event block.
// Assumes it is bound onto ptpc_clock_events; one clock, sync reset.
`timescale 1ns/10ps
module ptpc_events_chk (
    // Clock, reset, enable
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        ce,
    // Controls
    input wire logic        wr_en,
    input wire logic        snapshot_req,
    input wire logic        reload_add,
    input wire logic [8:0]  irq_enable,
    input wire logic [1:0]  pin_out_en,
    input wire logic [3:0]  pin_mode,
    input wire logic [1:0]  pin_pol,
    input wire logic [2:0]  rx_stamp_evt,
    // Observed outputs
    input wire logic [1:0]  pin_out,
    input wire logic [63:0] time_now,
    input wire logic [31:0] time_high_word,
    input wire logic [31:0] time_low_word,
    input wire logic [31:0] match_time_high,
    input wire logic [31:0] match_time_low,
    input wire logic [31:0] next_match_high,
    input wire logic [31:0] next_match_low_or_step,
    input wire logic [8:0]  timestamp_irq_status,
    input wire logic        timestamp_summary_flag
);
    import ptpc_pkg::*;
    logic [63:0] tgt;
    logic        eq;
    logic        eq_ff;
    logic        hit;
    assign tgt = {match_time_high, match_time_low};
    assign eq  = time_now == tgt;
    assign hit = ce && eq && !eq_ff;
    // History starts at one, so equal reset values are no event
    always_ff @(posedge clk) begin
        if (srst) begin
            eq_ff <= 1'b1;
        end else if (ce) begin
            eq_ff <= eq;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_summary_mask: assert property ($past(ce) |->
        timestamp_summary_flag == |(timestamp_irq_status & $past(irq_enable)))
        else $error("summary differs from enabled flags");
    a_time_step: assert property ($past(ce) && !$past(wr_en) |->
        time_now - $past(time_now) <= 64'h1) else $error("time moved by more than one");
    a_snap_copy: assert property (ce && snapshot_req |=>
        {time_high_word, time_low_word} == $past(time_now)) else $error("snapshot wrong");
    a_snap_hold: assert property (!(ce && snapshot_req) |=>
        $stable({time_high_word, time_low_word})) else $error("snapshot moved");
    a_match_flag: assert property (hit |=> timestamp_irq_status[FLG_TIMER])
        else $error("match did not set timer flag");
    a_match_add: assert property (hit && !reload_add && !wr_en |=>
        tgt == $past(tgt) + {32'h0, $past(next_match_low_or_step)})
        else $error("target step wrong");
    a_match_reload: assert property (hit && reload_add && !wr_en |=>
        tgt == $past({next_match_high, next_match_low_or_step})) else $error("reload wrong");
    a_pulse_width: assert property (hit && pin_mode[1:0] == MODE_PULSE && pin_pol[0]
        && pin_out_en[0] |=> pin_out[0] [*4] ##1 !pin_out[0]) else $error("pulse width wrong");
    a_rx_flag: assert property (ce && rx_stamp_evt[0] |=>
        timestamp_irq_status[FLG_RX_LSB]) else $error("rx flag not set");
    a_ce_freeze: assert property (!ce |=> $stable(time_now)
        && $stable(timestamp_irq_status)) else $error("state moved while disabled");
endmodule : ptpc_events_chk

bind ptpc_clock_events ptpc_events_chk u_chk (.*);

// File: dv/tb_ptpc_clock_events.sv
// Self-checking bench for the time clock and target event block.
// Assumes the checker is bound separately; inputs change at falling edges.
`timescale 1ns/10ps
module tb_ptpc_clock_events;
    import ptpc_pkg::*;
    typedef struct {int k; logic [63:0] v;} ptpc_note_t;
    logic clk = 1'h0, srst = 1'h1, ce = 1'h1, wr_en = 1'h0, snapshot_req = 1'h0;
    logic reload_add = 1'h0, timestamp_summary_flag;
    ptpc_sel_t wr_sel = SEL_TIME_LO;
    logic [31:0] wr_data = 32'h0, addend = 32'h0;
    logic [8:0]  irq_clear = 9'h0, irq_enable = 9'h0, timestamp_irq_status;
    logic [1:0]  pin_out_en = 2'h0, pin_pol = 2'h3, pin_clr_en = 2'h0, pin_in = 2'h0;
    logic [1:0]  pin_out, pin_oe;
    logic [3:0]  pin_mode = 4'h0;
    logic [2:0]  rx_stamp_evt = 3'h0, tx_stamp_evt = 3'h0;
    logic [63:0] time_now, pin0_cap_time, pin1_cap_time, v, t;
    logic [31:0] time_high_word, time_low_word, match_time_high, match_time_low;
    logic [31:0] next_match_high, next_match_low_or_step;
    logic [1:0]  modes [4] = '{2'h1, 2'h0, 2'h2, 2'h1};
    int fail_count = 0, checks = 0, nmatch = 0;
    ptpc_note_t q[$];
    event obs_ev;

    ptpc_clock_events dut (.*);

    always #12.5 clk = ~clk;

    function automatic logic [63:0] obs(input int k);
        case (k)
            0: return time_now;
            1: return {time_high_word, time_low_word};
            2: return {match_time_high, match_time_low};
            3: return 64'(timestamp_irq_status);
            4: return 64'(timestamp_summary_flag);
            5: return 64'({pin_oe, pin_out});
            6: return pin0_cap_time;
            7: return pin1_cap_time;
            default: return {next_match_high, next_match_low_or_step};
        endcase
    endfunction : obs

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic expect_now(input int k, input logic [63:0] e);
        q.push_back('{k, e});
        -> obs_ev;
    endtask : expect_now

    // Drains the queue so notes pushed in one time step are never lost
    always @(obs_ev) begin
        ptpc_note_t n;
        while (q.size() > 0) begin
            n = q.pop_front();
            check(obs(n.k), n.v);
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic wr(input ptpc_sel_t s, input logic [31:0] d);
        wr_sel = s;
        wr_data = d;
        wr_en = 1'h1;
        cyc(1);
    endtask : wr

    task automatic wr64(input ptpc_sel_t s, input logic [63:0] d);
        wr(s, d[31:0]);
        wr(ptpc_sel_t'(s + 3'h1), d[63:32]);
        wr_en = 1'h0;
    endtask : wr64

    // Addend is zero here, so the written time only matches by the write
    task automatic fire(input logic [63:0] tv);
        wr64(SEL_TIME_LO, tv);
        nmatch++;
        cyc(1);
    endtask : fire

    task automatic pulse_clear(input logic [8:0] m);
        irq_clear = m;
        cyc(1);
        irq_clear = 9'h0;
    endtask : pulse_clear

    task automatic complete_run;
        if (fail_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        v = $urandom(32'hCBFC);
        cyc(5);
        srst = 1'h0;
        expect_now(0, 64'h0);
        expect_now(3, 64'h0);
        wr(SEL_TIME_HI, 32'h2);
        wr_en = 1'h0;
        expect_now(0, 64'h0);
        wr(SEL_TIME_LO, 32'hFFFFFFFE);
        wr_en = 1'h0;
        expect_now(0, 64'h2_FFFFFFFE);
        snapshot_req = 1'h1;
        cyc(1);
        snapshot_req = 1'h0;
        expect_now(1, 64'h2_FFFFFFFE);
        // Half-rate addend: one tick every two clocks
        addend = 32'h80000000;
        cyc(20);
        addend = 32'h0;
        expect_now(1, 64'h2_FFFFFFFE);
        expect_now(0, 64'h3_00000008);
        snapshot_req = 1'h1;
        cyc(1);
        snapshot_req = 1'h0;
        expect_now(1, 64'h3_00000008);
        // Disabled clock: a running addend must not move the time
        addend = 32'h80000000;
        ce = 1'h0;
        cyc(4);
        ce = 1'h1;
        addend = 32'h0;
        expect_now(0, 64'h3_00000008);
        irq_enable = 9'h100;
        wr64(SEL_RLD_LO, 64'h5);
        expect_now(8, 64'h5);
        for (int i = 0; i < 2; i++) begin
            t = i ? 64'hFFFFFFFF_FFFFFFFE : 64'h1234_00000000;
            wr(SEL_TGT_HI, t[63:32]);
            wr(SEL_TGT_LO, t[31:0]);
            wr_en = 1'h0;
            expect_now(2, t);
            fire(t);
            expect_now(3, 64'h100);
            expect_now(4, 64'h1);
            expect_now(2, t + 64'h5);
            pulse_clear(9'h100);
            expect_now(3, 64'h0);
        end
        // Time itself rolls past zero onto the wrapped target
        addend = 32'h80000000;
        cyc(10);
        addend = 32'h0;
        nmatch++;
        cyc(1);
        expect_now(3, 64'h100);
        expect_now(2, 64'h8);
        reload_add = 1'h1;
        wr64(SEL_RLD_LO, 64'hA5A50000_00000042);
        expect_now(8, 64'hA5A50000_00000042);
        fire(64'h8);
        expect_now(2, 64'hA5A50000_00000042);
        pin_clr_en = 2'h1;
        pin_in = 2'h2;
        cyc(1);
        pin_in = 2'h1;
        cyc(6);
        pin_in = 2'h0;
        cyc(4);
        expect_now(3, 64'h40);
        expect_now(6, 64'h8);
        expect_now(7, 64'h0);
        pulse_clear(9'h1FF);
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            irq_enable = v[8:0];
            rx_stamp_evt = v[11:9];
            tx_stamp_evt = v[14:12];
            cyc(1);
            rx_stamp_evt = 3'h0;
            tx_stamp_evt = 3'h0;
            expect_now(3, 64'(v[14:9]));
            expect_now(4, 64'(|(v[14:9] & v[5:0])));
            pulse_clear(9'h1FF);
        end
        reload_add = 1'h0;
        pin_out_en = 2'h3;
        t = 64'hA5A50000_00000042;
        foreach (modes[i]) begin
            pin_mode = {2'h3, modes[i]};
            fire(t);
            t = t + 64'h42;
            v = (modes[i] == MODE_TOGGLE) ? 64'(nmatch % 2) : 64'h1;
            expect_now(5, 64'hC | v);
            cyc(6);
            pulse_clear(9'h100);
        end
        cyc(2);
        complete_run();
    end
endmodule : tb_ptpc_clock_events

// File: hw/ptpc_clock_events.sv
// Precision time clock with target comparator, pin events and flags.
// Assumes one 40 MHz clock; host writes arrive as one-cycle strobes.
`timescale 1ns/10ps
module ptpc_clock_events (
    // Clock, reset, enable
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic                      ce,
    // Host word writes and commands
    input  wire logic                      wr_en,
    input  wire ptpc_pkg::ptpc_sel_t       wr_sel,
    input  wire logic [31:0]               wr_data,
    input  wire logic                      snapshot_req,
    input  wire logic [8:0]                irq_clear,
    // Configuration
    input  wire logic [31:0]               addend,
    input  wire logic                      reload_add,
    input  wire logic [8:0]                irq_enable,
    input  wire logic [1:0]                pin_out_en,
    input  wire logic [3:0]                pin_mode,
    input  wire logic [1:0]                pin_pol,
    input  wire logic [1:0]                pin_clr_en,
    // Packet time stamp events
    input  wire logic [2:0]                rx_stamp_evt,
    input  wire logic [2:0]                tx_stamp_evt,
    // Time stamp pins
    input  wire logic [1:0]                pin_in,
    output logic      [1:0]                pin_out,
    output logic      [1:0]                pin_oe,
    // Readback
    output logic      [63:0]               time_now,
    output logic      [31:0]               time_high_word,
    output logic      [31:0]               time_low_word,
    output logic      [31:0]               match_time_high,
    output logic      [31:0]               match_time_low,
    output logic      [31:0]               next_match_high,
    output logic      [31:0]               next_match_low_or_step,
    output logic      [63:0]               pin0_cap_time,
    output logic      [63:0]               pin1_cap_time,
    output logic      [8:0]                timestamp_irq_status,
    output logic                           timestamp_summary_flag
);
    import ptpc_pkg::*;

    if (PULSE_CYC < 1) begin : g_chk
        $error("ptpc_clock_events: pulse must last at least one cycle");
    end

    if (N_FLAGS != 9 || FLG_TIMER != N_FLAGS - 1) begin : g_chk_flags
        $error("ptpc_clock_events: flag map must fill the nine status bits");
    end

    if (N_PINS != 2 || FLG_PIN_LSB + N_PINS != FLG_TIMER) begin : g_chk_pins
        $error("ptpc_clock_events: pin flags must match the two pin ports");
    end

    if (N_PORTS != 3 || FLG_TX_LSB + N_PORTS != FLG_PIN_LSB) begin : g_chk_ports
        $error("ptpc_clock_events: stamp flags must match the event ports");
    end

    if (N_PAIRS != 3 || PULSE_CYC >= (1 << PULSE_CNT_W)) begin : g_chk_pairs
        $error("ptpc_clock_events: three pairs and a fitting pulse count needed");
    end

    // Clock state
    logic [31:0]             acc_ff;
    logic [63:0]             time_ff;
    logic [63:0]             target_ff;
    logic [63:0]             reload_ff;
    logic [63:0]             snap_ff;
    logic                    match_prev_ff;
    logic [31:0]             nxt_acc;
    logic [63:0]             nxt_time;
    logic [63:0]             nxt_target;
    logic [63:0]             nxt_reload;
    logic [63:0]             nxt_snap;
    logic                    nxt_match_prev;

    // Pair staging
    logic [2:0][31:0]        stage_ff;
    logic [2:0][1:0]         seen_ff;
    logic [2:0][31:0]        nxt_stage;
    logic [2:0][1:0]         nxt_seen;
    logic [2:0]              commit;
    logic [2:0][63:0]        commit_val;

    // Flags and pins
    logic [8:0]              flags_ff;
    logic                    summary_ff;
    logic [1:0][63:0]        cap_ff;
    logic [1:0][PULSE_CNT_W-1:0] pulse_ff;
    logic [1:0]              toggle_ff;
    logic [1:0]              pin_out_ff;
    logic [1:0]              pin_oe_ff;
    logic [8:0]              nxt_flags;
    logic                    nxt_summary;
    logic [1:0][63:0]        nxt_cap;
    logic [1:0][PULSE_CNT_W-1:0] nxt_pulse;
    logic [1:0]              nxt_toggle;
    logic [1:0]              nxt_pin_out;

    logic [1:0]              pin_edge;
    logic                    carry;
    logic                    match_evt;
    logic [8:0]              flag_set;
    logic [8:0]              flag_clr;
    logic                    pin_act;

    // Pin input qualifiers
    for (genvar i = 0; i < N_PINS; i++) begin : g_pin
        ptpc_pin_in #(
            .FILT_CYC    (FILT_CYC)
        ) u_pin_in (
            .clk         (clk),
            .srst        (srst),
            .ce          (ce),
            .pin_in      (pin_in[i]),
            .active_high (pin_pol[i]),
            .edge_pulse  (pin_edge[i])
        );
    end

    // Pair staging and commit
    always_comb begin
        nxt_stage  = stage_ff;
        nxt_seen   = seen_ff;
        commit     = 3'h0;
        commit_val = '0;
        for (int p = 0; p < N_PAIRS; p++) begin
            if (wr_en && (int'(wr_sel[2:1]) == p)) begin
                if (seen_ff[p][~wr_sel[0]]) begin
                    commit[p]   = 1'b1;
                    commit_val[p] = wr_sel[0] ? {wr_data, stage_ff[p]}
                                              : {stage_ff[p], wr_data};
                    nxt_seen[p] = 2'h0;
                end else begin
                    nxt_stage[p]            = wr_data;
                    nxt_seen[p][wr_sel[0]]  = 1'b1;
                end
            end
        end
    end

    // Staging registers of the three pairs
    always_ff @(posedge clk) begin
        if (srst) begin
            stage_ff <= '0;
            seen_ff  <= '0;
        end else if (ce) begin
            stage_ff <= nxt_stage;
            seen_ff  <= nxt_seen;
        end
    end

    // Accumulator, time and match history
    always_comb begin
        {carry, nxt_acc} = {1'b0, acc_ff} + {1'b0, addend};
        // Natural 64-bit wrap past zero
        nxt_time = time_ff + 64'(carry);
        if (commit[PAIR_TIME]) begin
            nxt_time = commit_val[PAIR_TIME];
        end

        // Edge of equality: fires once even if time dwells on the target
        nxt_match_prev = (time_ff == target_ff);
        match_evt      = nxt_match_prev && !match_prev_ff;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            acc_ff        <= ACC_RST;
            time_ff       <= TIME_RST;
            match_prev_ff <= MATCH_PREV_RST;
        end else if (ce) begin
            acc_ff        <= nxt_acc;
            time_ff       <= nxt_time;
            match_prev_ff <= nxt_match_prev;
        end
    end

    // Target and reload pairs
    always_comb begin
        nxt_reload = reload_ff;
        if (commit[PAIR_RLD]) begin
            nxt_reload = commit_val[PAIR_RLD];
        end

        // A zero step leaves the target put; the edge detect stops a refire
        nxt_target = target_ff;
        if (match_evt) begin
            if (reload_add) begin
                nxt_target = reload_ff;
            end else begin
                nxt_target = target_ff + {32'h0, reload_ff[31:0]};
            end
        end
        // A host target write beats the automatic update
        if (commit[PAIR_TGT]) begin
            nxt_target = commit_val[PAIR_TGT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            target_ff <= TARGET_RST;
            reload_ff <= RELOAD_RST;
        end else if (ce) begin
            target_ff <= nxt_target;
            reload_ff <= nxt_reload;
        end
    end

    // Snapshot copy; held between commands so both word reads agree
    always_comb begin
        nxt_snap = snap_ff;
        if (snapshot_req) begin
            nxt_snap = time_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            snap_ff <= TIME_RST;
        end else if (ce) begin
            snap_ff <= nxt_snap;
        end
    end

    // Flags, summary, captures
    always_comb begin
        flag_set = '0;
        flag_clr = irq_clear;
        nxt_cap  = cap_ff;
        flag_set[FLG_RX_LSB +: N_PORTS] = rx_stamp_evt;
        flag_set[FLG_TX_LSB +: N_PORTS] = tx_stamp_evt;
        flag_set[FLG_TIMER]             = match_evt;
        for (int i = 0; i < N_PINS; i++) begin
            if (pin_edge[i] && !pin_out_en[i]) begin
                nxt_cap[i]                = time_ff;
                flag_set[FLG_PIN_LSB + i] = 1'b1;
                if (pin_clr_en[i]) begin
                    flag_clr[FLG_TIMER] = 1'b1;
                end
            end
        end
        // A new event outweighs a clear in the same cycle
        nxt_flags   = (flags_ff & ~flag_clr) | flag_set;
        nxt_summary = |(nxt_flags & irq_enable);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flags_ff   <= '0;
            summary_ff <= 1'b0;
            cap_ff     <= '0;
        end else if (ce) begin
            flags_ff   <= nxt_flags;
            summary_ff <= nxt_summary;
            cap_ff     <= nxt_cap;
        end
    end

    // Output pin events; state advances even while the pin is an input
    // Pulse length is whole cycles, so it rounds down to the clock period
    always_comb begin
        pin_act     = 1'b0;
        nxt_pulse   = pulse_ff;
        nxt_toggle  = toggle_ff;
        nxt_pin_out = pin_out_ff;
        for (int i = 0; i < N_PINS; i++) begin
            if (match_evt) begin
                nxt_pulse[i]  = PULSE_CNT_W'(PULSE_CYC);
                nxt_toggle[i] = ~toggle_ff[i];
            end else if (pulse_ff[i] != '0) begin
                nxt_pulse[i] = pulse_ff[i] - PULSE_CNT_W'(1);
            end
            case (pin_mode[2*i +: 2])
                MODE_PULSE:  pin_act = (nxt_pulse[i] != '0);
                MODE_TOGGLE: pin_act = nxt_toggle[i];
                MODE_FOLLOW: pin_act = nxt_flags[FLG_TIMER];
                default:     pin_act = 1'b0;
            endcase
            nxt_pin_out[i] = pin_pol[i] ? pin_act : ~pin_act;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pulse_ff   <= '0;
            toggle_ff  <= 2'h0;
            pin_out_ff <= 2'h0;
            pin_oe_ff  <= 2'h0;
        end else if (ce) begin
            pulse_ff   <= nxt_pulse;
            toggle_ff  <= nxt_toggle;
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff  <= pin_out_en;
        end
    end

    // Outputs, all straight from flops
    assign time_now               = time_ff;
    assign time_high_word         = snap_ff[63:32];
    assign time_low_word          = snap_ff[31:0];
    assign match_time_high        = target_ff[63:32];
    assign match_time_low         = target_ff[31:0];
    assign next_match_high        = reload_ff[63:32];
    assign next_match_low_or_step = reload_ff[31:0];
    assign pin0_cap_time          = cap_ff[0];
    assign pin1_cap_time          = cap_ff[1];
    assign timestamp_irq_status   = flags_ff;
    assign timestamp_summary_flag = summary_ff;
    assign pin_out                = pin_out_ff;
    assign pin_oe                 = pin_oe_ff;

endmodule : ptpc_clock_events

// File: hw/ptpc_pin_in.sv
// Input qualifier for one time stamp pin: synchroniser plus width filter.
// Assumes the pin is asynchronous to clk; emits one pulse per active edge.
`timescale 1ns/10ps
module ptpc_pin_in #(
    parameter int FILT_CYC = ptpc_pkg::FILT_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ce,
    // Pin and polarity
    input  wire logic pin_in,
    input  wire logic active_high,
    // Qualified edge
    output logic      edge_pulse
);
    import ptpc_pkg::*;

    localparam int CNT_W = $clog2(FILT_CYC + 1);

    if (FILT_CYC < 1) begin : g_chk
        $error("ptpc_pin_in: FILT_CYC must be at least 1");
    end

    logic [2:0]       sync_ff;
    logic             level_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             edge_ff;
    logic             nxt_level;
    logic [CNT_W-1:0] nxt_cnt;
    logic             nxt_edge;

    always_comb begin
        nxt_level = level_ff;
        // Level changes only when second and third stages agree
        if (sync_ff[1] == sync_ff[2]) begin
            nxt_level = sync_ff[2];
        end
        nxt_cnt  = '0;
        nxt_edge = 1'b0;
        if (nxt_level == active_high) begin
            nxt_cnt = cnt_ff;
            if (cnt_ff < CNT_W'(FILT_CYC)) begin
                nxt_cnt = cnt_ff + CNT_W'(1);
            end
            // Fires once, after the pin has stayed active long enough
            nxt_edge = (cnt_ff == CNT_W'(FILT_CYC - 1));
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            // Start at the idle level, else an active-low pin fakes an edge
            sync_ff  <= {3{~active_high}};
            level_ff <= ~active_high;
            cnt_ff   <= '0;
            edge_ff  <= 1'b0;
        end else if (ce) begin
            sync_ff  <= {sync_ff[1:0], pin_in};
            level_ff <= nxt_level;
            cnt_ff   <= nxt_cnt;
            edge_ff  <= nxt_edge;
        end
    end

    assign edge_pulse = edge_ff;

endmodule : ptpc_pin_in

// File: shared/ptpc_pkg.sv
// Constants and types of the precision time clock block.
// Assumes a single 40 MHz clock; no bus, all controls are plain ports.
package ptpc_pkg;

    localparam int TIME_W  = 64;
    localparam int WORD_W  = 32;
    localparam int N_PAIRS = 3;
    localparam int N_PINS  = 2;
    localparam int N_PORTS = 3;

    // Host write word selects; pair index in bits 2:1, half in bit 0
    typedef enum logic [2:0] {
        SEL_TIME_LO = 3'h0,
        SEL_TIME_HI = 3'h1,
        SEL_TGT_LO  = 3'h2,
        SEL_TGT_HI  = 3'h3,
        SEL_RLD_LO  = 3'h4,
        SEL_RLD_HI  = 3'h5
    } ptpc_sel_t;

    localparam int PAIR_TIME = 0;
    localparam int PAIR_TGT  = 1;
    localparam int PAIR_RLD  = 2;

    // Flag positions in the interrupt status vector
    localparam int FLG_RX_LSB = 0;
    localparam int FLG_TX_LSB = 3;
    localparam int FLG_PIN_LSB = 6;
    localparam int FLG_TIMER  = 8;
    localparam int N_FLAGS    = 9;

    // Output pin event modes
    localparam logic [1:0] MODE_PULSE  = 2'h0;
    localparam logic [1:0] MODE_TOGGLE = 2'h1;
    localparam logic [1:0] MODE_FOLLOW = 2'h2;

    // Reset values
    localparam logic [63:0] TIME_RST   = 64'h0;
    localparam logic [63:0] TARGET_RST = 64'h0;
    localparam logic [63:0] RELOAD_RST = 64'h0;
    localparam logic [31:0] ACC_RST    = 32'h0;
    // Stops a spurious event when time and target both reset to zero
    localparam logic        MATCH_PREV_RST = 1'b1;

    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int PULSE_NS      = 100;
    localparam int PULSE_CYC     = PULSE_NS / CLK_PERIOD_NS;
    localparam int PULSE_CNT_W   = $clog2(PULSE_CYC + 1);
    localparam int FILT_NS       = 40;
    localparam int FILT_CYC      = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : ptpc_pkg
